// >>> hdl/sa_pkg.sv
// Shared constants, field layouts and carriers for the streaming offset generators
`default_nettype none
package sa_pkg;
   // --------------------------------------------------
   // Sizes
   // --------------------------------------------------
   localparam int NUM_GEN  = 4;
   localparam int NUM_LVL  = 6;
   localparam int WORD_W   = 32;
   localparam int TPL_W    = 512;
   localparam int FIELD_W  = 3;
   // --------------------------------------------------
   // Template word indexes (32-bit words)
   // --------------------------------------------------
   localparam int W_ITER0   = 0;
   localparam int W_STRIP_A = 6;
   localparam int W_STRIP_B = 7;
   localparam int W_STRIDE1 = 8;
   localparam int W_FLAGS   = 13;
   // --------------------------------------------------
   // Flag field positions within the template
   // --------------------------------------------------
   localparam int F_DIMCNT  = W_FLAGS * WORD_W + 0;
   localparam int F_SPAN    = W_FLAGS * WORD_W + 4;
   localparam int F_DEC_A   = W_FLAGS * WORD_W + 8;
   localparam int F_DEC_B   = W_FLAGS * WORD_W + 12;
   localparam logic [2:0] DIMCNT_MAX = 3'h5;
   localparam logic [2:0] SPAN_MAX   = 3'h6;
   localparam logic [2:0] DEC_MAX    = 3'h5;
   localparam logic [2:0] DEC_NORMAL = 3'h0;
   // --------------------------------------------------
   // Addressing modes and offset-register selections
   // --------------------------------------------------
   localparam logic [2:0] MODE_SCALED  = 3'h2;
   localparam logic [2:0] MODE_ADVANCE = 3'h6;
   localparam logic [4:0] SEL_GEN_TOP  = 5'h03;
   localparam logic [4:0] SEL_RSV_TOP  = 5'h07;
   localparam int         BRK_END_LVL  = 5;
   localparam logic [TPL_W-1:0] TPL_RESET = '0;
   // --------------------------------------------------
   // Enumerations and carriers
   // --------------------------------------------------
   typedef enum logic [1:0] {
      OP_NONE  = 2'b00,
      OP_OPEN  = 2'b01,
      OP_CLOSE = 2'b10,
      OP_BREAK = 2'b11
   } gen_op_e;
   typedef struct packed {
      gen_op_e             kind;
      logic [1:0]          gen;
      logic [2:0]          levels;
      logic [TPL_W-1:0]    tpl;
   } gen_op_s;
   typedef struct packed {
      logic [NUM_LVL-1:0][WORD_W-1:0] remain;
      logic [NUM_LVL-1:0][WORD_W-1:0] lvlStart;
      logic [WORD_W-1:0]              offset;
      logic [WORD_W-1:0]              stripA;
      logic [WORD_W-1:0]              stripB;
      logic                           done;
   } gen_state_s;
   typedef struct packed {
      logic          valid;
      logic [2:0]    mode;
      logic [4:0]    offSel;
      logic          predTrue;
      logic [2:0]    sizeLog2;
      logic [63:0]   base;
      logic [63:0]   regValue;
   } addr_req_s;
   typedef struct packed {
      logic          valid;
      logic          illegal;
      logic          isGen;
      logic          baseWrite;
      logic [63:0]   addr;
      logic [63:0]   newBase;
      logic [6:0]    elemCount;
   } addr_rsp_s;
   typedef struct packed {
      logic             valid;
      logic             write;
      logic             debug;
      logic [1:0]       gen;
      logic             selCount;
      logic [TPL_W-1:0] wdata;
   } ctl_move_s;
   typedef struct packed {
      logic             valid;
      logic             fault;
      logic [TPL_W-1:0] rdata;
   } ctl_rsp_s;
endpackage : sa_pkg
`default_nettype wire

// >>> hdl/streaming_offset_generator.sv
// Four streaming offset generators with addressing-mode and offset-select decode
// --------------------------------------------------
// --------------------------------------------------
`default_nettype none
module streaming_offset_generator #(
   parameter int NUM_SLOTS = 2
) (
   input  wire logic                                ref_clk,
   input  wire logic                                nrst,
   input  wire sa_pkg::gen_op_s                     genOp,
   input  wire sa_pkg::addr_req_s [NUM_SLOTS-1:0]   addrReq,
   input  wire sa_pkg::ctl_move_s                   ctlMove,
   output var sa_pkg::addr_rsp_s [NUM_SLOTS-1:0]    addrRsp,
   output var sa_pkg::ctl_rsp_s                     ctlRsp,
   output logic [sa_pkg::NUM_GEN-1:0]               activeBits
);
   import sa_pkg::*;

   // --------------------------------------------------
   // Field helpers
   // --------------------------------------------------
   function automatic logic [2:0] fld(input logic [TPL_W-1:0] tpl, input int lsb);
      fld = tpl[lsb +: FIELD_W];
   endfunction : fld

   function automatic logic [WORD_W-1:0] word(input logic [TPL_W-1:0] tpl, input int idx);
      word = tpl[idx*WORD_W +: WORD_W];
   endfunction : word

   function automatic logic [WORD_W-1:0] span_elems(input logic [TPL_W-1:0] tpl);
      span_elems = WORD_W'(1) << fld(tpl, F_SPAN);
   endfunction : span_elems

   function automatic logic tpl_bad(input logic [TPL_W-1:0] tpl);
      tpl_bad = (fld(tpl, F_DIMCNT) > DIMCNT_MAX) || (fld(tpl, F_SPAN) > SPAN_MAX)
              || (fld(tpl, F_DEC_A) > DEC_MAX) || (fld(tpl, F_DEC_B) > DEC_MAX);
   endfunction : tpl_bad

   function automatic logic [WORD_W-1:0] sat_sub(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b);
      sat_sub = (a > b) ? a - b : '0;
   endfunction : sat_sub

   function automatic logic [WORD_W-1:0] min32(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b);
      min32 = (a < b) ? a : b;
   endfunction : min32

   // --------------------------------------------------
   // Fresh state for an open
   // --------------------------------------------------
   function automatic gen_state_s open_state(input logic [TPL_W-1:0] tpl);
      gen_state_s st;
      st = '0;
      for (int l = 0; l < NUM_LVL; l++) begin
         st.remain[l] = word(tpl, W_ITER0 + l);
      end
      st.stripA = word(tpl, W_STRIP_A);
      st.stripB = word(tpl, W_STRIP_B);
      // Strip A narrower than count 0 clips the first row as well
      if (fld(tpl, F_DEC_A) != DEC_NORMAL) begin
         st.remain[0] = min32(st.remain[0], st.stripA);
      end
      st.offset = '0;
      st.done   = (st.remain[0] == '0);
      open_state = st;
   endfunction : open_state

   // --------------------------------------------------
   // Move to the next iteration of the lowest live level at or above fromLvl
   // --------------------------------------------------
   function automatic gen_state_s step_nest(input gen_state_s st, input logic [TPL_W-1:0] tpl,
                                            input int fromLvl);
      gen_state_s        ns;
      int                tgt;
      int                dims;
      logic [WORD_W-1:0] nOff;
      logic [WORD_W-1:0] iter0;
      logic [WORD_W-1:0] width0;
      ns     = st;
      tgt    = NUM_LVL;
      dims   = int'(fld(tpl, F_DIMCNT)) + 1;
      nOff   = '0;
      iter0  = word(tpl, W_ITER0);
      width0 = iter0;
      for (int l = NUM_LVL - 1; l >= 1; l--) begin
         if (l >= fromLvl && l < dims && st.remain[l] > WORD_W'(1)) begin
            tgt = l;
         end
      end
      if (tgt == NUM_LVL) begin
         ns.done   = 1'b1;
         ns.offset = '0;
         ns.remain = '0;
      end else begin
         nOff = st.lvlStart[tgt] + word(tpl, W_STRIDE1 + tgt - 1);
         ns.remain[tgt]   = st.remain[tgt] - WORD_W'(1);
         ns.lvlStart[tgt] = nOff;
         for (int l = 0; l < NUM_LVL; l++) begin
            if (l < tgt) begin
               ns.remain[l]   = word(tpl, W_ITER0 + l);
               ns.lvlStart[l] = nOff;
            end
         end
         // Strip widths shrink by one row of level 0 on each step at or above their level
         if (fld(tpl, F_DEC_A) != DEC_NORMAL && tgt >= int'(fld(tpl, F_DEC_A))) begin
            ns.stripA = sat_sub(st.stripA, iter0);
            width0    = min32(width0, ns.stripA);
         end
         if (fld(tpl, F_DEC_B) != DEC_NORMAL && tgt >= int'(fld(tpl, F_DEC_B))) begin
            ns.stripB = sat_sub(st.stripB, iter0);
            width0    = min32(width0, ns.stripB);
         end
         ns.remain[0] = width0;
         ns.offset    = nOff;
         ns.done      = (width0 == '0);
      end
      step_nest = ns;
   endfunction : step_nest

   // --------------------------------------------------
   // One advance by the span
   // --------------------------------------------------
   function automatic gen_state_s advance(input gen_state_s st, input logic [TPL_W-1:0] tpl);
      gen_state_s ns;
      ns = st;
      // Finished generator holds still; its zero offset comes from the done flag
      if (st.done) begin
         ns = st;
      end else if (st.remain[0] > span_elems(tpl)) begin
         ns.remain[0] = st.remain[0] - span_elems(tpl);
         ns.offset    = st.offset + span_elems(tpl);
      end else begin
         ns = step_nest(st, tpl, 1);
      end
      advance = ns;
   endfunction : advance

   // --------------------------------------------------
   // State
   // --------------------------------------------------
   logic [TPL_W-1:0] tpl_ff    [NUM_GEN];
   gen_state_s       st_ff     [NUM_GEN];
   logic             open_ff   [NUM_GEN];
   logic [TPL_W-1:0] nxt_tpl   [NUM_GEN];
   gen_state_s       nxt_st    [NUM_GEN];
   logic             nxt_open  [NUM_GEN];
   addr_rsp_s [NUM_SLOTS-1:0] nxt_addrRsp;
   ctl_rsp_s                  nxt_ctlRsp;

   // --------------------------------------------------
   // Per-slot decode
   // --------------------------------------------------
   logic [NUM_SLOTS-1:0]          slotGen;
   logic [NUM_SLOTS-1:0]          slotRsv;
   logic [NUM_SLOTS-1:0]          slotMode;
   logic [NUM_SLOTS-1:0][1:0]     slotIdx;
   logic [NUM_SLOTS-1:0]          slotBad;
   logic [NUM_SLOTS-1:0][NUM_GEN-1:0] slotAdv;
   logic [NUM_GEN-1:0]            advReq;

   for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
      assign slotMode[s] = (addrReq[s].mode == MODE_SCALED) || (addrReq[s].mode == MODE_ADVANCE);
      assign slotGen[s]  = addrReq[s].offSel <= SEL_GEN_TOP;
      assign slotRsv[s]  = !slotGen[s] && (addrReq[s].offSel <= SEL_RSV_TOP);
      assign slotIdx[s]  = addrReq[s].offSel[1:0];
      assign slotBad[s]  = !slotMode[s] || slotRsv[s]
                         || (slotGen[s] && (!open_ff[slotIdx[s]] || tpl_bad(tpl_ff[slotIdx[s]])));
      for (genvar g = 0; g < NUM_GEN; g++) begin : g_adv
         assign slotAdv[s][g] = addrReq[s].valid && !slotBad[s] && slotGen[s]
                              && (addrReq[s].mode == MODE_ADVANCE) && addrReq[s].predTrue
                              && (slotIdx[s] == 2'(g));
      end
   end

   // Parallel advances of one generator collapse into one step
   always_comb begin
      advReq = '0;
      for (int s = 0; s < NUM_SLOTS; s++) begin
         advReq = advReq | slotAdv[s];
      end
   end

   // --------------------------------------------------
   // Addressing answers
   // --------------------------------------------------
   always_comb begin
      logic [63:0] offElems;
      logic [63:0] scaled;
      gen_state_s  cur;
      offElems    = '0;
      scaled      = '0;
      cur         = '0;
      nxt_addrRsp = '0;
      for (int s = 0; s < NUM_SLOTS; s++) begin
         cur = st_ff[slotIdx[s]];
         if (slotGen[s]) begin
            offElems = cur.done ? 64'h0 : {{32{cur.offset[WORD_W-1]}}, cur.offset};
         end else begin
            offElems = addrReq[s].regValue;
         end
         scaled = offElems << addrReq[s].sizeLog2;
         nxt_addrRsp[s].valid   = addrReq[s].valid;
         nxt_addrRsp[s].illegal = slotBad[s];
         nxt_addrRsp[s].isGen   = slotGen[s] && !slotBad[s];
         nxt_addrRsp[s].newBase = addrReq[s].base;
         if (!slotBad[s]) begin
            if (addrReq[s].mode == MODE_ADVANCE && !slotGen[s]) begin
               nxt_addrRsp[s].addr      = addrReq[s].base;
               nxt_addrRsp[s].newBase   = addrReq[s].base + scaled;
               nxt_addrRsp[s].baseWrite = addrReq[s].valid;
            end else begin
               nxt_addrRsp[s].addr = addrReq[s].base + scaled;
            end
            if (slotGen[s]) begin
               nxt_addrRsp[s].elemCount =
                  cur.done ? 7'h00 : 7'(min32(cur.remain[0], span_elems(tpl_ff[slotIdx[s]])));
            end
         end
      end
   end

   // --------------------------------------------------
   // Generator next state: open/close, then control move, then break, then advance
   // --------------------------------------------------
   // Fault and zero data both; debugger keeps access for state save and restore
   logic cmRefused;
   assign cmRefused = ctlMove.valid && open_ff[ctlMove.gen] && !ctlMove.debug;

   always_comb begin
      for (int g = 0; g < NUM_GEN; g++) begin
         nxt_tpl[g]  = tpl_ff[g];
         nxt_st[g]   = st_ff[g];
         nxt_open[g] = open_ff[g];
         if (genOp.kind == OP_OPEN && genOp.gen == 2'(g)) begin
            nxt_tpl[g]  = genOp.tpl;
            nxt_st[g]   = open_state(genOp.tpl);
            nxt_open[g] = 1'b1;
         end else if (genOp.kind == OP_CLOSE && genOp.gen == 2'(g)) begin
            nxt_tpl[g]  = TPL_RESET;
            nxt_st[g]   = '0;
            nxt_open[g] = 1'b0;
         end else if (ctlMove.valid && ctlMove.write && !cmRefused && ctlMove.gen == 2'(g)) begin
            if (ctlMove.selCount) begin
               for (int l = 0; l < NUM_LVL; l++) begin
                  nxt_st[g].remain[l] = word(ctlMove.wdata, l);
               end
               nxt_st[g].stripA = word(ctlMove.wdata, W_STRIP_A);
               nxt_st[g].stripB = word(ctlMove.wdata, W_STRIP_B);
               nxt_st[g].done   = (word(ctlMove.wdata, W_ITER0) == '0);
            end else begin
               nxt_tpl[g] = ctlMove.wdata;
            end
         end else if (genOp.kind == OP_BREAK && genOp.gen == 2'(g) && open_ff[g]) begin
            if (int'(genOp.levels) >= BRK_END_LVL) begin
               nxt_st[g] = step_nest(st_ff[g], tpl_ff[g], NUM_LVL);
            end else if (genOp.levels != 3'h0) begin
               nxt_st[g] = step_nest(st_ff[g], tpl_ff[g], int'(genOp.levels));
            end
         end else if (advReq[g]) begin
            nxt_st[g] = advance(st_ff[g], tpl_ff[g]);
         end
      end
   end

   // --------------------------------------------------
   // Control move read path
   // --------------------------------------------------
   always_comb begin
      logic [TPL_W-1:0] view;
      gen_state_s       cs;
      cs   = st_ff[ctlMove.gen];
      view = '0;
      if (ctlMove.selCount) begin
         for (int l = 0; l < NUM_LVL; l++) begin
            view[l*WORD_W +: WORD_W] = cs.remain[l];
         end
         view[W_STRIP_A*WORD_W +: WORD_W] = cs.stripA;
         view[W_STRIP_B*WORD_W +: WORD_W] = cs.stripB;
      end else begin
         view = tpl_ff[ctlMove.gen];
      end
      nxt_ctlRsp.valid = ctlMove.valid;
      nxt_ctlRsp.fault = cmRefused;
      // Refused reads give zeros too, so a handler ignoring the fault sees nothing stale
      nxt_ctlRsp.rdata = (ctlMove.valid && !ctlMove.write && !cmRefused) ? view : '0;
   end

   // --------------------------------------------------
   // Registers
   // --------------------------------------------------
   // Answers registered so every output leaves a flip-flop; costs one cycle of latency
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         for (int g = 0; g < NUM_GEN; g++) begin
            tpl_ff[g]  <= TPL_RESET;
            st_ff[g]   <= '0;
            open_ff[g] <= 1'b0;
         end
         addrRsp    <= '0;
         ctlRsp     <= '0;
         activeBits <= '0;
      end else begin
         for (int g = 0; g < NUM_GEN; g++) begin
            tpl_ff[g]     <= nxt_tpl[g];
            st_ff[g]      <= nxt_st[g];
            open_ff[g]    <= nxt_open[g];
            activeBits[g] <= nxt_open[g];
         end
         addrRsp <= nxt_addrRsp;
         ctlRsp  <= nxt_ctlRsp;
      end
   end
endmodule : streaming_offset_generator
`default_nettype wire

// >>> bench/streaming_offset_generator_props.sv
// Port checker for the streaming offset generators
`default_nettype none
module sog_checker #(
   parameter int NUM_SLOTS = 2
) (
   input wire logic                              ref_clk,
   input wire logic                              nrst,
   input wire sa_pkg::gen_op_s                   genOp,
   input wire sa_pkg::addr_req_s [NUM_SLOTS-1:0] addrReq,
   input wire sa_pkg::ctl_move_s                 ctlMove,
   input wire sa_pkg::addr_rsp_s [NUM_SLOTS-1:0] addrRsp,
   input wire sa_pkg::ctl_rsp_s                  ctlRsp,
   input wire logic [sa_pkg::NUM_GEN-1:0]        activeBits
);
   timeunit 1ns;
   timeprecision 1ps;
   import sa_pkg::*;
   addr_req_s q;
   addr_rsp_s p;
   logic      okMode;
   // Slot 0 only: every slot has its own identical copy of the decoder
   assign q = addrReq[0];
   assign p = addrRsp[0];
   assign okMode = (q.mode == MODE_SCALED) || (q.mode == MODE_ADVANCE);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   sequence s_genReq;
      q.valid && okMode && q.offSel <= SEL_GEN_TOP && genOp.kind == OP_NONE;
   endsequence
   sequence s_regReq;
      q.valid && okMode && q.offSel > SEL_RSV_TOP;
   endsequence
   chk_rsp_latency: assert property (p.valid == $past(q.valid))
      else $error("response valid not one cycle after request");
   chk_bad_mode: assert property (q.valid && !okMode |=> p.illegal && p.addr == 64'h0)
      else $error("unknown mode not refused");
   chk_rsv_select: assert property (q.valid && q.offSel > SEL_GEN_TOP && q.offSel <= SEL_RSV_TOP |=> p.illegal)
      else $error("reserved offset select not refused");
   chk_reg_postinc: assert property (s_regReq ##0 q.mode == MODE_ADVANCE |=> p.baseWrite && p.addr == $past(q.base)
      && p.newBase == $past(q.base) + ($past(q.regValue) << $past(q.sizeLog2)))
      else $error("post-increment result wrong");
   chk_reg_scaled: assert property (s_regReq ##0 q.mode == MODE_SCALED |=> !p.baseWrite && !p.illegal
      && p.addr == $past(q.base) + ($past(q.regValue) << $past(q.sizeLog2)))
      else $error("scaled register address wrong");
   chk_gen_nobase: assert property (s_genReq |=> !p.baseWrite)
      else $error("generator access wrote the base");
   chk_closed_gen: assert property (s_genReq ##0 !activeBits[q.offSel[1:0]] |=> p.illegal)
      else $error("closed generator not refused");
   chk_open_sets: assert property (genOp.kind == OP_OPEN |=> activeBits[$past(genOp.gen)])
      else $error("open left active bit low");
   chk_close_clears: assert property (genOp.kind == OP_CLOSE |=> !activeBits[$past(genOp.gen)])
      else $error("close left active bit high");
   chk_move_refused: assert property (ctlMove.valid && !ctlMove.debug && activeBits[ctlMove.gen]
      && genOp.kind == OP_NONE |=> ctlRsp.valid && ctlRsp.fault && ctlRsp.rdata == '0)
      else $error("move on open generator not refused");
endmodule : sog_checker
bind streaming_offset_generator sog_checker #(.NUM_SLOTS(NUM_SLOTS)) u_sogChk (
   .ref_clk(ref_clk), .nrst(nrst), .genOp(genOp), .addrReq(addrReq), .ctlMove(ctlMove),
   .addrRsp(addrRsp), .ctlRsp(ctlRsp), .activeBits(activeBits));
`default_nettype wire

// >>> bench/exec_unit_model.sv
// Behavioural model of the load, store and address-arithmetic units
`default_nettype none
module exec_unit_model #(
   parameter int NUM_SLOTS = 2
) (
   input  wire logic                               ref_clk,
   output var sa_pkg::addr_req_s [NUM_SLOTS-1:0]   addrReq,
   input  wire sa_pkg::addr_rsp_s [NUM_SLOTS-1:0]  addrRsp
);
   timeunit 1ns;
   timeprecision 1ps;
   import sa_pkg::*;
   initial addrReq = '0;
   // All slots issue together; released fields are inverted so stale data never looks valid
   task automatic issue(input logic [2:0] m, input logic [4:0] s, input logic [NUM_SLOTS-1:0] pv,
                        input logic [63:0] b, input logic [63:0] rv, input logic [2:0] sz,
                        output addr_rsp_s r0, output addr_rsp_s r1);
      @(posedge ref_clk);
      for (int i = 0; i < NUM_SLOTS; i++) addrReq[i] <= '{1'b1, m, s, pv[i], sz, b, rv};
      @(posedge ref_clk);
      for (int i = 0; i < NUM_SLOTS; i++) addrReq[i] <= '{1'b0, ~m, ~s, 1'b0, ~sz, ~b, ~rv};
      #1;
      r0 = addrRsp[0];
      r1 = addrRsp[1];
   endtask : issue
endmodule : exec_unit_model
`default_nettype wire

// >>> bench/streaming_offset_generator_tb.sv
// Self-checking bench for the streaming offset generators
`default_nettype none
module streaming_offset_generator_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sa_pkg::*;
   logic               ref_clk = 1'b0;
   logic               nrst = 1'b0;
   gen_op_s            genOp = '0;
   ctl_move_s          ctlMove = '0;
   addr_req_s [1:0]    addrReq;
   addr_rsp_s [1:0]    addrRsp;
   ctl_rsp_s           ctlRsp;
   logic [NUM_GEN-1:0] activeBits;
   int                 error_cnt = 0;
   int                 comparisons = 0;
   logic [31:0]        seed = 32'h025722F2;
   always #2.5 ref_clk = ~ref_clk;
   streaming_offset_generator #(.NUM_SLOTS(2)) dut (
      .ref_clk(ref_clk), .nrst(nrst), .genOp(genOp), .addrReq(addrReq),
      .ctlMove(ctlMove), .addrRsp(addrRsp), .ctlRsp(ctlRsp), .activeBits(activeBits));
   exec_unit_model #(.NUM_SLOTS(2)) u_ex (.ref_clk(ref_clk), .addrReq(addrReq), .addrRsp(addrRsp));
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xorshift
   // Outer counts of 1 keep the stream two-dimensional; strip widths match count 0 so no row is clipped
   function automatic logic [TPL_W-1:0] mkTpl(input logic [31:0] c0, c1, d1, flg);
      logic [TPL_W-1:0] t;
      t = '0;
      for (int i = 0; i < NUM_LVL; i++) t[i*WORD_W +: WORD_W] = 32'h1;
      t[W_ITER0*WORD_W +: WORD_W] = c0;
      t[W_STRIP_A*WORD_W +: WORD_W] = c0;
      t[W_STRIP_B*WORD_W +: WORD_W] = c0;
      t[(W_ITER0+1)*WORD_W +: WORD_W] = c1;
      t[W_STRIDE1*WORD_W +: WORD_W] = d1;
      t[W_FLAGS*WORD_W +: WORD_W] = flg;
      return t;
   endfunction : mkTpl
   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
      end
   endtask : check
   task automatic gop(input gen_op_e k, input logic [1:0] g, input logic [2:0] lv, input logic [TPL_W-1:0] t);
      @(posedge ref_clk);
      genOp <= '{k, g, lv, t};
      @(posedge ref_clk);
      genOp <= '0;
      #1;
   endtask : gop
   task automatic mv(input logic w, dbg, input logic [1:0] g, input logic sc, input logic [TPL_W-1:0] wd,
                     output ctl_rsp_s r);
      @(posedge ref_clk);
      ctlMove <= '{1'b1, w, dbg, g, sc, wd};
      @(posedge ref_clk);
      ctlMove <= '0;
      #1;
      r = ctlRsp;
   endtask : mv
   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test
   initial begin
      #50us;
      error_cnt++;
      finish_test();
   end
   initial begin
      ctl_rsp_s         cr;
      addr_rsp_s        r0;
      addr_rsp_s        r1;
      logic [TPL_W-1:0] tpl;
      logic [2:0]       sz;
      logic [2:0]       m;
      logic [1:0]       pv;
      logic [63:0]      b;
      logic [31:0]      st;
      logic [31:0]      off;
      logic             bad;
      int               step;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      mv(1'b0, 1'b1, 2'h0, 1'b0, '0, cr);
      check(activeBits, 64'h0, "reset active");
      check(cr.rdata == '0, 64'h1, "reset template");
      st = 32'(xorshift() % 64) - 32'h20;
      tpl = mkTpl(32'h5, 32'h3, st, 32'h11);
      mv(1'b1, 1'b0, 2'h0, 1'b0, tpl, cr);
      check(cr.fault, 64'h0, "closed write");
      mv(1'b0, 1'b0, 2'h0, 1'b0, '0, cr);
      check(cr.rdata == tpl, 64'h1, "template readback");
      gop(OP_OPEN, 2'h0, 3'h0, tpl);
      check(activeBits, 64'h1, "open");
      mv(1'b1, 1'b0, 2'h0, 1'b0, ~tpl, cr);
      check({cr.fault, cr.rdata == '0}, 64'h3, "open move");
      mv(1'b0, 1'b1, 2'h0, 1'b1, '0, cr);
      check(cr.rdata[63:0], {32'h3, 32'h5}, "counts loaded");
      mv(1'b0, 1'b1, 2'h0, 1'b0, '0, cr);
      check(cr.rdata == tpl, 64'h1, "template kept");
      $display("test registers done");
      step = 0;
      for (int n = 0; n < 60 && step < 10; n++) begin
         sz = 3'(xorshift() % 4);
         b = {xorshift(), xorshift()};
         pv = (n == 1) ? 2'h0 : 2'(xorshift());
         m = (xorshift() % 3 == 0) ? MODE_SCALED : MODE_ADVANCE;
         off = (step < 9) ? 32'(step / 3) * st + 32'(step % 3 * 2) : 32'h0;
         u_ex.issue(m, 5'h00, pv, b, 64'h0, sz, r0, r1);
         check(r0.addr, b + (64'(signed'(off)) << sz), "offset");
         check(r1.addr, r0.addr, "shared offset");
         check(r0.elemCount, step > 8 ? 0 : step % 3 == 2 ? 1 : 2, "element count");
         check({r0.illegal, r0.baseWrite, r0.isGen}, 64'h1, "base kept");
         if (m == MODE_ADVANCE && pv != 2'h0) step++;
      end
      check(step, 10, "walk length");
      gop(OP_OPEN, 2'h0, 3'h0, tpl);
      u_ex.issue(MODE_SCALED, 5'h00, 2'h3, 64'h100, 64'h0, 3'h0, r0, r1);
      check({r0.addr[31:0], r0.elemCount}, {32'h100, 7'h2}, "reopen");
      $display("test walk done");
      gop(OP_OPEN, 2'h2, 3'h0, mkTpl(32'h4, 32'h2, 32'h32, 32'h1));
      u_ex.issue(MODE_ADVANCE, 5'h02, 2'h1, 64'h0, 64'h0, 3'h0, r0, r1);
      gop(OP_BREAK, 2'h2, 3'h1, '0);
      u_ex.issue(MODE_SCALED, 5'h02, 2'h1, 64'h0, 64'h0, 3'h0, r0, r1);
      check(r0.addr, 64'h32, "break one");
      gop(OP_BREAK, 2'h2, 3'h5, '0);
      u_ex.issue(MODE_SCALED, 5'h02, 2'h1, 64'h0, 64'h0, 3'h0, r0, r1);
      check({activeBits[2], r0.addr[31:0], r0.elemCount}, {1'b1, 39'h0}, "break five");
      gop(OP_CLOSE, 2'h2, 3'h0, '0);
      u_ex.issue(MODE_SCALED, 5'h02, 2'h1, 64'h0, 64'h0, 3'h0, r0, r1);
      mv(1'b0, 1'b1, 2'h2, 1'b0, '0, cr);
      check({activeBits[2], r0.illegal, cr.rdata == '0}, 64'h3, "close");
      $display("test break done");
      for (int n = 0; n < 32; n++) begin
         bad = (n % 8) > ((n / 8 == 1) ? 6 : 5);
         gop(OP_OPEN, 2'h1, 3'h0, mkTpl(32'hC8, 32'h1, 32'h0, 32'(n % 8) << (4 * (n / 8))));
         u_ex.issue(MODE_ADVANCE, 5'h01, 2'h3, 64'h0, 64'h0, 3'h0, r0, r1);
         check(r0.illegal, bad, "field code");
         u_ex.issue(MODE_SCALED, 5'h01, 2'h3, 64'h0, 64'h0, 3'h0, r0, r1);
         check(r0.addr, bad ? 0 : n / 8 == 1 ? 1 << n % 8 : 1, "span step");
      end
      $display("test codes done");
      // Last pass picks a reserved selection under a legal mode
      for (int n = 0; n < 9; n++) begin
         m = (n == 8) ? MODE_SCALED : 3'(n);
         u_ex.issue(m, n == 8 ? 5'h05 : 5'(8 + xorshift() % 24), 2'h3, {xorshift(), xorshift()},
                    64'(xorshift()), 3'(xorshift() % 4), r0, r1);
         check({r0.illegal, r0.baseWrite}, {n == 8 || !(n == 2 || n == 6), n == 6}, "mode");
      end
      $display("test modes done");
      finish_test();
   end
endmodule : streaming_offset_generator_tb
`default_nettype wire
